// >>> vgs_defs.svh
// constants of the voice group sequencer: field positions, reset values, times
`ifndef VGS_DEFS_SVH
`define VGS_DEFS_SVH
`define VGS_CLK_HZ 100000000
`define VGS_DEB_LONG_MS 50
`define VGS_DEB_SHORT_US 400
`define VGS_POR_MS 160
`define VGS_BLINK_HZ 3
`define VGS_RATE0_HZ 4000
`define VGS_RATE1_HZ 4800
`define VGS_RATE2_HZ 6000
`define VGS_RATE3_HZ 8000
`define VGS_POI_GROUP 8'h20
`define VGS_EN_RST 8'hff
`define VGS_STOP_RST 3'h7
`define VGS_PTR_RST 8'h00
// mode nibble holds option register bits 7:4, so these index the nibble
`define VGS_MODE_RST 4'hf
`define VGS_MODE_BLINK 3
`define VGS_MODE_PIN4SEL 2
`define VGS_MODE_PINFN 1
`define VGS_MODE_DEB 0
// program word fields
`define VGS_OP_HI 23
`define VGS_OP_LO 20
`define VGS_COND_HI 19
`define VGS_COND_LO 18
`define VGS_TSEL_HI 17
`define VGS_TSEL_LO 16
`define VGS_TLVL 15
`define VGS_OPND_HI 7
`define VGS_JPIMM_HI 6
`define VGS_GR_HI 3
`define VGS_REP_HI 19
`define VGS_REP_LO 17
`define VGS_RATE_HI 16
`define VGS_RATE_LO 15
`define VGS_LAMP 14
`define VGS_SND_HI 13
`define VGS_SIL_HI 16
`endif

// >>> vgs_pkg.sv
// types of the voice group sequencer
package vgs_pkg;
  typedef enum logic [3:0] {
    VGS_OP_END = 4'h0,
    VGS_OP_LD_PTR = 4'h1,
    VGS_OP_LD_EN = 4'h2,
    VGS_OP_LD_STOP = 4'h3,
    VGS_OP_LD_MODE = 4'h4,
    VGS_OP_JP_IMM = 4'h5,
    VGS_OP_JP_PTR = 4'h6,
    VGS_OP_SECTION = 4'h7,
    VGS_OP_SILENCE = 4'h8,
    VGS_OP_GR = 4'h9,
    VGS_OP_GR_END = 4'ha
  } vgs_op_t;
  typedef enum logic [1:0] {
    VGS_CND_NONE = 2'h0,
    VGS_CND_LAST = 2'h1,
    VGS_CND_PIN = 2'h2
  } vgs_cond_t;
  typedef enum logic [2:0] {S_POR, S_FETCH, S_PLAY, S_SILENCE, S_IDLE} vgs_state_t;
endpackage : vgs_pkg

// >>> vgs_seq_monitor.sv
// port checker for the voice group sequencer
`timescale 1ns/1ps
module vgs_seq_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_play_done,
  input wire logic o_lamp_out_one,
  input wire logic o_halt_signal_a,
  input wire logic o_halt_signal_b,
  input wire logic o_shared_pin_four_oe_n,
  input wire logic o_play_start,
  input wire logic o_play_abort,
  input wire logic [13:0] o_play_sound,
  input wire logic [1:0] o_play_rate,
  input wire logic o_mute,
  input wire logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========
  // sequences
  sequence s_run;
    !o_mute ##1 !o_mute;
  endsequence
  sequence s_section_over;
    i_play_done && !o_play_abort;
  endsequence
  // ==========
  // properties
  rst_state_a: assert property (disable iff (1'b0) !i_rst_n |=> o_halt_signal_a && o_halt_signal_b &&
    o_shared_pin_four_oe_n && !o_lamp_out_one && o_mute && !o_busy) else $error("reset state wrong");
  por_wait_a: assert property ($rose(i_rst_n) |-> !o_busy [*8]) else $error("busy during power-up wait");
  start_once_a: assert property (o_play_start |=> !o_play_start) else $error("start not a pulse");
  abort_once_a: assert property (o_play_abort |=> !o_play_abort) else $error("abort not a pulse");
  lamp_play_a: assert property (o_lamp_out_one |-> !o_mute && o_busy) else $error("lamp outside play");
  start_live_a: assert property (o_play_start |-> o_busy ##1 !o_mute) else $error("start while muted");
  idle_quiet_a: assert property (!o_busy |-> !o_play_start && o_mute) else $error("activity while idle");
  rate_hold_a: assert property (s_run |-> $stable(o_play_rate) && $stable(o_play_sound))
    else $error("rate or sound changed in play");
  next_rep_a: assert property (s_section_over |=> o_play_start or ##1 o_mute) else $error("no repeat or fetch");
endmodule : vgs_seq_monitor
bind vgs_sequencer vgs_seq_monitor u_mon (.i_core_clk, .i_rst_n, .i_play_done, .o_lamp_out_one,
  .o_halt_signal_a, .o_halt_signal_b, .o_shared_pin_four_oe_n, .o_play_start, .o_play_abort,
  .o_play_sound, .o_play_rate, .o_mute, .o_busy);

// >>> vgs_seq_partner.sv
// program store and sound decoder beside the sequencer
`timescale 1ns/1ps
module vgs_seq_partner (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_prog_addr,
  output logic [23:0] o_prog_word,
  input wire logic i_play_start,
  input wire logic i_play_abort,
  input wire logic i_slow,
  output logic o_play_done
);
  int left_q;
  // ==========
  // program store, unlisted words end the group
  always_comb begin
    case (i_prog_addr)
      16'h2000: o_prog_word = 24'h48_0000;
      16'h2001: o_prog_word = 24'h30_0002;
      16'h2002: o_prog_word = 24'h28_800f;
      16'h0000: o_prog_word = 24'h90_0001;
      16'h0001: o_prog_word = 24'h75_4123;
      16'h0002: o_prog_word = 24'h80_0003;
      16'h0003: o_prog_word = 24'h54_0011;
      16'h0004: o_prog_word = 24'ha0_0000;
      16'h1100: o_prog_word = 24'h10_0099;
      16'h1101: o_prog_word = 24'h18_8040;
      16'h1102: o_prog_word = 24'h60_0000;
      16'h0200: o_prog_word = 24'h40_00a0;
      16'h0300: o_prog_word = 24'h71_c3ff;
      default: o_prog_word = 24'h00_0000;
    endcase
  end
  // ==========
  // decoder: slow play outlasts a debounce so triggers can cut in
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_play_abort) left_q <= 0;
    else if (i_play_start) left_q <= i_slow ? 60 : 4;
    else if (left_q > 0) left_q <= left_q - 1;
    o_play_done <= i_rst_n && !i_play_abort && !i_play_start && left_q == 1;
  end
endmodule : vgs_seq_partner

// >>> vgs_sequencer.sv
// voice group sequencer: trigger debounce, program execution, lamp and halt outputs
`timescale 1ns/1ps
`include "vgs_defs.svh"
module vgs_sequencer #(
  parameter int DEB_LONG_CYC = `VGS_CLK_HZ / 1000 * `VGS_DEB_LONG_MS,
  parameter int DEB_SHORT_CYC = `VGS_CLK_HZ / 1000000 * `VGS_DEB_SHORT_US,
  parameter int POR_CYC = `VGS_CLK_HZ / 1000 * `VGS_POR_MS,
  parameter int BLINK_HALF_CYC = `VGS_CLK_HZ / (2 * `VGS_BLINK_HZ),
  parameter int RATE0_CYC = `VGS_CLK_HZ / `VGS_RATE0_HZ,
  parameter int RATE1_CYC = `VGS_CLK_HZ / `VGS_RATE1_HZ,
  parameter int RATE2_CYC = `VGS_CLK_HZ / `VGS_RATE2_HZ,
  parameter int RATE3_CYC = `VGS_CLK_HZ / `VGS_RATE3_HZ,
  parameter int CNT_W = 25,
  parameter int PC_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_trigger_in_one,
  input wire logic i_trigger_in_two,
  input wire logic i_trigger_in_three,
  input wire logic i_shared_pin_four,
  output logic o_shared_pin_four,
  output logic o_shared_pin_four_oe_n,
  output logic o_lamp_out_one,
  output logic o_halt_signal_a,
  output logic o_halt_signal_b,
  output logic [8+PC_W-1:0] o_prog_addr,
  input wire logic [23:0] i_prog_word,
  output logic o_play_start,
  output logic o_play_abort,
  output logic [13:0] o_play_sound,
  output logic [1:0] o_play_rate,
  output logic o_sample_tick,
  output logic o_mute,
  output logic o_busy,
  input wire logic i_play_done
);
  // ==========================================================
  // trigger synchronise and debounce
  logic [3:0] trg_raw;
  logic [3:0] trg_lvl;
  logic [3:0] trg_rise;
  logic [3:0] trg_fall;
  logic [3:0] mode_q;
  logic [CNT_W-1:0] deb_lim;
  assign trg_raw = {i_shared_pin_four, i_trigger_in_three, i_trigger_in_two, i_trigger_in_one};
  assign deb_lim = mode_q[`VGS_MODE_DEB] ? CNT_W'(DEB_LONG_CYC) : CNT_W'(DEB_SHORT_CYC);
  for (genvar g = 0; g < 4; g++) begin : g_deb
    logic s1_q;
    logic s2_q;
    logic lvl_q;
    logic rise_q;
    logic fall_q;
    logic [CNT_W-1:0] cnt_q;
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
      end else begin
        s1_q <= trg_raw[g];
        s2_q <= s1_q;
      end
    end
    // pull-up idle level is high, so the debounced level starts high
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        lvl_q <= 1'b1;
        cnt_q <= '0;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        rise_q <= 1'b0;
        fall_q <= 1'b0;
        if (s2_q == lvl_q) begin
          cnt_q <= '0;
        end else if (cnt_q >= deb_lim - CNT_W'(1)) begin
          lvl_q <= s2_q;
          cnt_q <= '0;
          rise_q <= s2_q;
          fall_q <= !s2_q;
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
      end
    end
    assign trg_lvl[g] = lvl_q;
    assign trg_rise[g] = rise_q;
    assign trg_fall[g] = fall_q;
  end

  // ==========================================================
  // decode and interrupt selection
  vgs_pkg::vgs_state_t state_q;
  logic [7:0] group_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] ptr_q;
  logic [7:0] en_q;
  logic [2:0] stop_q;
  logic [3:0] gr_q;
  logic [3:0] pass_q;
  logic [PC_W-1:0] loop_pc_q;
  logic [2:0] rep_q;
  logic lamp_flag_q;
  logic [16:0] sil_q;
  logic tick;
  vgs_pkg::vgs_op_t op;
  vgs_pkg::vgs_cond_t cnd;
  logic cond_ok;
  logic [7:0] ev;
  logic irq;
  logic [7:0] irq_grp;
  logic exec;
  logic [1:0] tsel;

  assign op = vgs_pkg::vgs_op_t'(i_prog_word[`VGS_OP_HI:`VGS_OP_LO]);
  assign cnd = vgs_pkg::vgs_cond_t'(i_prog_word[`VGS_COND_HI:`VGS_COND_LO]);
  assign tsel = i_prog_word[`VGS_TSEL_HI:`VGS_TSEL_LO];
  assign o_prog_addr = {group_q, pc_q};
  // edge vector order matches entry groups 7..0; trigger four edges dead while pin four is an output
  assign ev = {trg_rise[3] & mode_q[`VGS_MODE_PINFN], trg_rise[2:0],
               trg_fall[3] & mode_q[`VGS_MODE_PINFN], trg_fall[2:0]} & en_q;
  assign irq = |ev;
  assign exec = (state_q == vgs_pkg::S_FETCH) && !irq;

  always_comb begin
    irq_grp = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (ev[i]) begin
        irq_grp = 8'(i);
      end
    end
  end

  always_comb begin
    unique case (cnd)
      vgs_pkg::VGS_CND_NONE: cond_ok = 1'b1;
      vgs_pkg::VGS_CND_LAST: cond_ok = (pass_q == gr_q);
      vgs_pkg::VGS_CND_PIN: cond_ok = (trg_lvl[tsel] == i_prog_word[`VGS_TLVL]);
      default: cond_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // program loads of the four registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ptr_q <= `VGS_PTR_RST;
      en_q <= `VGS_EN_RST;
      stop_q <= `VGS_STOP_RST;
      mode_q <= `VGS_MODE_RST;
    end else if (exec) begin
      if (op == vgs_pkg::VGS_OP_LD_MODE) begin
        mode_q <= i_prog_word[`VGS_OPND_HI:4];
      end else if (cond_ok) begin
        if (op == vgs_pkg::VGS_OP_LD_PTR) begin
          ptr_q <= i_prog_word[`VGS_OPND_HI:0];
        end
        if (op == vgs_pkg::VGS_OP_LD_EN) begin
          en_q <= i_prog_word[`VGS_OPND_HI:0];
        end
        if (op == vgs_pkg::VGS_OP_LD_STOP) begin
          stop_q <= i_prog_word[2:0];
        end
      end
    end
  end

  // ==========================================================
  // power-on delay
  logic [CNT_W-1:0] por_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      por_q <= '0;
    end else if (state_q == vgs_pkg::S_POR) begin
      por_q <= por_q + CNT_W'(1);
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= vgs_pkg::S_POR;
      group_q <= 8'h00;
      pc_q <= '0;
      gr_q <= 4'h0;
      pass_q <= 4'h0;
      loop_pc_q <= '0;
      rep_q <= 3'h0;
      lamp_flag_q <= 1'b0;
      o_play_sound <= 14'h0000;
      o_play_rate <= 2'h0;
      sil_q <= 17'h0_0000;
    end else if (irq) begin
      state_q <= vgs_pkg::S_FETCH;
      group_q <= irq_grp;
      pc_q <= '0;
      gr_q <= 4'h0;
      pass_q <= 4'h0;
    end else begin
      unique case (state_q)
        vgs_pkg::S_POR: begin
          if (por_q >= CNT_W'(POR_CYC - 1)) begin
            state_q <= vgs_pkg::S_FETCH;
            group_q <= `VGS_POI_GROUP;
            pc_q <= '0;
          end
        end
        vgs_pkg::S_FETCH: begin
          pc_q <= pc_q + PC_W'(1);
          unique case (op)
            vgs_pkg::VGS_OP_END: state_q <= vgs_pkg::S_IDLE;
            vgs_pkg::VGS_OP_JP_IMM: begin
              if (cond_ok) begin
                group_q <= {1'b0, i_prog_word[`VGS_JPIMM_HI:0]};
                pc_q <= '0;
              end
            end
            vgs_pkg::VGS_OP_JP_PTR: begin
              if (cond_ok) begin
                group_q <= ptr_q;
                pc_q <= '0;
              end
            end
            vgs_pkg::VGS_OP_GR: begin
              gr_q <= i_prog_word[`VGS_GR_HI:0];
              pass_q <= 4'h0;
              loop_pc_q <= pc_q + PC_W'(1);
            end
            vgs_pkg::VGS_OP_GR_END: begin
              if (pass_q != gr_q) begin
                pass_q <= pass_q + 4'h1;
                pc_q <= loop_pc_q;
              end
            end
            vgs_pkg::VGS_OP_SECTION: begin
              rep_q <= i_prog_word[`VGS_REP_HI:`VGS_REP_LO];
              o_play_rate <= i_prog_word[`VGS_RATE_HI:`VGS_RATE_LO];
              lamp_flag_q <= i_prog_word[`VGS_LAMP];
              o_play_sound <= i_prog_word[`VGS_SND_HI:0];
              state_q <= vgs_pkg::S_PLAY;
            end
            vgs_pkg::VGS_OP_SILENCE: begin
              sil_q <= i_prog_word[`VGS_SIL_HI:0];
              if (i_prog_word[`VGS_SIL_HI:0] != 17'h0_0000) begin
                state_q <= vgs_pkg::S_SILENCE;
              end
            end
            default: ;
          endcase
        end
        vgs_pkg::S_PLAY: begin
          if (i_play_done) begin
            if (rep_q > 3'h1) begin
              rep_q <= rep_q - 3'h1;
            end else begin
              state_q <= vgs_pkg::S_FETCH;
            end
          end
        end
        vgs_pkg::S_SILENCE: begin
          if (tick) begin
            sil_q <= sil_q - 17'h0_0001;
            if (sil_q == 17'h0_0001) begin
              state_q <= vgs_pkg::S_FETCH;
            end
          end
        end
        vgs_pkg::S_IDLE: ;
      endcase
    end
  end

  // ==========================================================
  // playback strobes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_play_start <= 1'b0;
      o_play_abort <= 1'b0;
    end else begin
      o_play_start <= (exec && op == vgs_pkg::VGS_OP_SECTION) ||
                      (!irq && state_q == vgs_pkg::S_PLAY && i_play_done && rep_q > 3'h1);
      o_play_abort <= irq && (state_q == vgs_pkg::S_PLAY || state_q == vgs_pkg::S_SILENCE);
    end
  end

  // ==========================================================
  // sample period timer, follows the last section rate
  logic [CNT_W-1:0] smp_q;
  logic [CNT_W-1:0] smp_lim;
  always_comb begin
    unique case (o_play_rate)
      2'h0: smp_lim = CNT_W'(RATE0_CYC);
      2'h1: smp_lim = CNT_W'(RATE1_CYC);
      2'h2: smp_lim = CNT_W'(RATE2_CYC);
      default: smp_lim = CNT_W'(RATE3_CYC);
    endcase
  end
  assign tick = (smp_q >= smp_lim - CNT_W'(1));
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      smp_q <= '0;
      o_sample_tick <= 1'b0;
    end else begin
      smp_q <= tick ? '0 : smp_q + CNT_W'(1);
      o_sample_tick <= tick;
    end
  end

  // ==========================================================
  // blink timer and pins
  logic [CNT_W-1:0] blk_q;
  logic blink_q;
  logic lamp_on;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      blk_q <= '0;
      blink_q <= 1'b1;
    end else if (blk_q >= CNT_W'(BLINK_HALF_CYC - 1)) begin
      blk_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blk_q <= blk_q + CNT_W'(1);
    end
  end
  // lamp phase is free running, so the first blink half may be short
  assign lamp_on = (state_q == vgs_pkg::S_PLAY) && lamp_flag_q &&
                   (mode_q[`VGS_MODE_BLINK] ? blink_q : 1'b1);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_lamp_out_one <= 1'b0;
      o_halt_signal_a <= 1'b1;
      o_halt_signal_b <= 1'b1;
      o_shared_pin_four <= 1'b1;
      o_shared_pin_four_oe_n <= 1'b1;
      o_mute <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      o_lamp_out_one <= lamp_on;
      o_halt_signal_a <= stop_q[0];
      o_halt_signal_b <= stop_q[1];
      o_shared_pin_four_oe_n <= mode_q[`VGS_MODE_PINFN];
      o_shared_pin_four <= mode_q[`VGS_MODE_PIN4SEL] ? lamp_on : stop_q[2];
      o_mute <= (state_q != vgs_pkg::S_PLAY);
      o_busy <= (state_q != vgs_pkg::S_IDLE) && (state_q != vgs_pkg::S_POR);
    end
  end
endmodule : vgs_sequencer

// >>> voice_group_sequencer_test.sv
// self-checking bench for the voice group sequencer
`timescale 1ns/1ps
module voice_group_sequencer_test;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic t1 = 1'b1, t2 = 1'b1, t3 = 1'b1, p4 = 1'b1, slow = 1'b0;
  logic p4o, oe_n, lamp, ha, hb, st, ab, tick, mute, busy, done, pin4;
  logic [15:0] addr;
  logic [23:0] word;
  logic [13:0] snd;
  logic [1:0] rate;
  logic [16:0] rnd = 17'h1_05ea;
  int failures = 0, compares = 0, cyc = 0, starts = 0, aborts = 0, lit = 0, ticks = 0, gr, rep, l0;
  logic [15:0] exp_q[$];
  // pull-up pin, device wins while it drives
  assign pin4 = oe_n ? p4 : p4o;
  always #5 i_core_clk = ~i_core_clk;
  // only rate two times silence and the tick check, the other rates keep their defaults
  vgs_sequencer #(.DEB_LONG_CYC(20), .DEB_SHORT_CYC(8), .POR_CYC(10), .BLINK_HALF_CYC(16),
    .RATE2_CYC(12)) dut (.i_core_clk, .i_rst_n,
    .i_trigger_in_one(t1), .i_trigger_in_two(t2), .i_trigger_in_three(t3), .i_shared_pin_four(pin4),
    .o_shared_pin_four(p4o), .o_shared_pin_four_oe_n(oe_n), .o_lamp_out_one(lamp), .o_halt_signal_a(ha),
    .o_halt_signal_b(hb), .o_prog_addr(addr), .i_prog_word(word), .o_play_start(st), .o_play_abort(ab),
    .o_play_sound(snd), .o_play_rate(rate), .o_sample_tick(tick), .o_mute(mute), .o_busy(busy),
    .i_play_done(done));
  vgs_seq_partner u_far (.i_core_clk, .i_rst_n, .i_prog_addr(addr), .o_prog_word(word),
    .i_play_start(st), .i_play_abort(ab), .i_slow(slow), .o_play_done(done));
  // ==========
  // helpers
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_addr(input logic [15:0] a);
    for (int i = 0; i < 400 && addr !== a; i++) @(negedge i_core_clk);
    chk("addr", 24'(a), 24'(addr));
  endtask : wait_addr
  task automatic settle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : settle
  always @(posedge i_core_clk) begin
    cyc++;
    starts += st;
    aborts += ab;
    lit += lamp;
    ticks += tick;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  // ==========
  // scenarios
  initial begin
    settle(12);
    i_rst_n = 1'b1;
    chk("reset", 24'h00_001c, 24'({ha, hb, oe_n, lamp, busy}));
    exp_q = '{16'h2000, 16'h2003};
    foreach (exp_q[i]) wait_addr(exp_q[i]);
    settle(3);
    chk("poi", 24'h00_0008, 24'({ha, hb, oe_n, p4o, busy}));
    $display("test power-up done");
    gr = 2;
    rep = 2;
    l0 = starts;
    t1 = 1'b0;
    exp_q = '{16'h0000, 16'h0003, 16'h1102, 16'h9900};
    foreach (exp_q[i]) wait_addr(exp_q[i]);
    settle(3);
    chk("starts", 24'(gr * rep), 24'(starts - l0));
    chk("rate", 24'h00_0002, 24'(rate));
    chk("sound", 24'h00_0123, 24'(snd));
    chk("end", 24'h00_0000, 24'(busy));
    t1 = 1'b1;
    settle(30);
    chk("rise", 24'h00_0000, 24'(busy));
    chk("rise addr", 24'h00_9901, 24'(addr));
    $display("test sections done");
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      t3 = 1'b0;
      settle(int'(rnd[1:0]) + 1);
      t3 = 1'b1;
      settle(12);
    end
    chk("bounce", 24'h00_0000, 24'(busy));
    chk("bounce addr", 24'h00_9901, 24'(addr));
    $display("test bounce done");
    slow = 1'b1;
    l0 = aborts;
    gr = starts;
    t1 = 1'b0;
    for (int i = 0; i < 200 && starts == gr; i++) @(negedge i_core_clk);
    t2 = 1'b0;
    wait_addr(16'h0100);
    settle(3);
    chk("abort", 24'h00_0001, 24'(aborts - l0));
    chk("stop", 24'h00_0000, 24'(busy));
    t1 = 1'b1;
    t2 = 1'b1;
    settle(30);
    $display("test abort done");
    t3 = 1'b0;
    wait_addr(16'h0201);
    settle(3);
    chk("pin dir", 24'h00_0001, 24'(oe_n));
    l0 = ticks;
    settle(24);
    chk("tick", 24'h00_0002, 24'(ticks - l0));
    t3 = 1'b1;
    settle(30);
    l0 = lit;
    p4 = 1'b0;
    wait_addr(16'h0301);
    settle(3);
    chk("rate", 24'h00_0003, 24'(rate));
    chk("blink", 24'h00_0001, 24'(lit - l0 > 0 && lit - l0 < 45));
    p4 = 1'b1;
    $display("test pin four done");
    summarize();
  end
endmodule : voice_group_sequencer_test
